// ### rtl/pcmts_pkg.sv
/*
  constants shared by the pcm highway slot assigner and its shifters.
  assumes one system clock; all pcm timing is counted in pcm bit clocks.
*/
package pcmts_pkg;
  localparam int SLOT_W = 7;
  localparam int OFS_W = 3;
  localparam int CNT_W = 11;
  localparam int WORD_W = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 11'h7FF;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
  localparam logic [1:0] PORT_SEL_A = 2'h1;
  localparam logic [1:0] PORT_SEL_B = 2'h2;
  localparam int SIG_DET1_BIT = 7;
  localparam int SIG_DET2_BIT = 6;
  localparam int SIG_CLOCK_FAIL_FLAG_BIT = 2;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  typedef enum logic [1:0] {
    CODE_ALAW,
    CODE_MULAW,
    CODE_LINEAR
  } pcmts_code_e;
endpackage

// ### rtl/pcmts_tx_shift.sv
/*
  transmit shifter: loads one 8 or 16 bit word and shifts it out msb first.
  assumes load, shift and abort are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ns
module pcmts_tx_shift
  import pcmts_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic load_i,
  input wire logic shift_i,
  input wire logic abort_i,
  input wire logic [4:0] len_i,
  input wire logic [pcmts_pkg::WORD_W-1:0] word_i,
  // serial side
  output logic bit_o,
  output logic busy_o
);
  import pcmts_pkg::*;

  logic [WORD_W-1:0] sr;
  logic [4:0] rem;

  assign bit_o = sr[WORD_W-1];

  // load wins over abort so a slot 0 start is not lost at frame sync
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sr <= WORD_RST;
      rem <= 5'h00;
      busy_o <= 1'b0;
    end else if (load_i) begin
      sr <= word_i;
      rem <= len_i - 5'h01;
      busy_o <= 1'b1;
    end else if (abort_i) begin
      busy_o <= 1'b0;
    end else if (shift_i && busy_o) begin
      if (rem == 5'h00) begin
        busy_o <= 1'b0;
      end else begin
        sr <= {sr[WORD_W-2:0], 1'b0};
        rem <= rem - 5'h01;
      end
    end
  end
endmodule // pcmts_tx_shift

// ### rtl/pcmts_rx_shift.sv
/*
  receive shifter with a-law and mu-law expander.
  assumes sample is a pulse; last is a level that marks the final bit of a sample.
*/
`timescale 1ns/1ns
module pcmts_rx_shift
  import pcmts_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // serial side
  input wire logic sample_i,
  input wire logic last_i,
  input wire logic bit_i,
  input wire pcmts_pkg::pcmts_code_e code_i,
  // parallel side
  output logic [pcmts_pkg::WORD_W-1:0] word_o,
  output logic valid_o
);
  import pcmts_pkg::*;

  logic [WORD_W-2:0] sr;
  logic [WORD_W-1:0] full;

  // g.711 expansion to 16-bit two's complement
  function automatic logic [WORD_W-1:0] expand(logic [7:0] c, logic mu);
    logic [7:0] x;
    int mag;
    x = mu ? ~c : (c ^ 8'h55);
    if (mu) begin
      mag = ((int'(x[3:0]) << 3) + 132) << x[6:4];
      mag = mag - 132;
    end else begin
      mag = int'(x[3:0]) << 4;
      if (x[6:4] == 3'h0) begin
        mag = mag + 8;
      end else begin
        mag = (mag + 264) << (x[6:4] - 3'h1);
      end
    end
    // mu-law sign bit set means negative, a-law set means positive
    if (x[7] ^ ~mu) begin
      mag = -mag;
    end
    return mag[WORD_W-1:0];
  endfunction

  assign full = {sr, bit_i};

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sr <= 15'h0000;
    end else if (sample_i) begin
      sr <= full[WORD_W-2:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      word_o <= WORD_RST;
      valid_o <= 1'b0;
    end else begin
      valid_o <= sample_i && last_i;
      if (sample_i && last_i) begin
        word_o <= (code_i == CODE_LINEAR) ? full :
          expand(full[7:0], code_i == CODE_MULAW);
      end
    end
  end
endmodule // pcmts_rx_shift

// ### rtl/pcmts_assigner.sv
/*
  pcm highway time slot assigner for one codec channel: transmit slot,
  clock slot, port and edge selection, signalling byte, receive slot and
  port selection. assumes config ports are static between frames and come
  from the command interface on mclk; pcm clock, frame marker and receive
  data are pins and are resynchronised here.
*/
// Functional notes
// - linear sample spans two back-to-back slots
// - companded sample is one byte, one slot
// - signalling byte follows companded byte when enabled
// - frame marker defines transmit slot zero
// - slot selectors are seven bits wide
// - works for 128 khz to 8.192 mhz clocks
// - bytes leave msb first
// - three-bit clock slot delays by 0-7 bits
// - fractional slot keeps strobe active, data undefined
// - receive last full slot unusable past remainder
// - port a, b or both, strobes low
// - transmit outputs change on selected clock edge
// - transmitted word readable by the command interface
// - expander used unless linear coding selected
// - frame marker defines receive slot zero
// - receive data taken from one selected port
// - law or linear picked by one setting
// - linear words two's complement, sign first
// - signalling byte carries detects and clock fail
`timescale 1ns/1ns
module pcmts_assigner
  import pcmts_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // pcm highway pins
  input wire logic pcm_clk_i,
  input wire logic frame_marker_i,
  input wire logic rx_data_port_a_i,
  input wire logic rx_data_port_b_i,
  output logic tx_data_port_a_o,
  output logic tx_data_port_b_o,
  output logic tx_slot_active_a_n_o,
  output logic tx_slot_active_b_n_o,
  // configuration
  input wire logic [pcmts_pkg::SLOT_W-1:0] tx_slot_select_i,
  input wire logic [pcmts_pkg::OFS_W-1:0] tx_bit_offset_i,
  input wire logic [pcmts_pkg::SLOT_W-1:0] rx_slot_select_i,
  input wire logic [pcmts_pkg::OFS_W-1:0] rx_bit_offset_i,
  input wire pcmts_pkg::pcmts_code_e code_sel_i,
  input wire logic pcm_signalling_select_i,
  input wire logic [1:0] tx_port_sel_i,
  input wire logic rx_port_b_sel_i,
  input wire logic tx_edge_rising_i,
  // signalling sources
  input wire logic line_detect_one_i,
  input wire logic line_detect_two_i,
  input wire logic line_detect_alt_i,
  input wire logic line_alt_sel_i,
  input wire logic clock_fail_flag_i,
  // signal processor side
  input wire logic [pcmts_pkg::WORD_W-1:0] tx_sample_i,
  output logic [pcmts_pkg::WORD_W-1:0] rx_word_o,
  output logic rx_valid_o,
  output logic [pcmts_pkg::WORD_W-1:0] tx_readback_o
);
  import pcmts_pkg::*;

  logic [SYNC_STAGES-1:0] pclk_sync;
  logic [SYNC_STAGES-1:0] fs_sync;
  logic [SYNC_STAGES-1:0] dra_sync;
  logic [SYNC_STAGES-1:0] drb_sync;
  logic pclk_prev;
  logic fs_prev;
  logic frame_seen;
  logic pclk_rise;
  logic pclk_fall;
  logic frame_start;
  logic tx_edge;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] tx_pos;
  logic [CNT_W-1:0] tx_start;
  logic [CNT_W-1:0] rx_start;
  logic [CNT_W-1:0] rx_end;
  logic [4:0] tx_len;
  logic [4:0] rx_len;
  logic linear;
  logic sig_en;
  logic [7:0] sig_byte;
  logic [WORD_W-1:0] tx_hold;
  logic [WORD_W-1:0] tx_src;
  logic [WORD_W-1:0] tx_word;
  logic tx_load;
  logic tx_bit;
  logic tx_busy;
  logic rx_sample;
  logic rx_last;
  logic rx_bit;

  // slot start in bit clocks from the frame marker
  function automatic logic [CNT_W-1:0] slot_start(
    logic [SLOT_W-1:0] slot, logic [OFS_W-1:0] ofs);
    return {1'b0, slot, 3'b000} + {8'h00, ofs};
  endfunction

  // pins pass two flops; only the second stage is read
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pclk_sync <= '0;
      fs_sync <= '0;
      dra_sync <= '0;
      drb_sync <= '0;
    end else begin
      pclk_sync <= {pclk_sync[0], pcm_clk_i};
      fs_sync <= {fs_sync[0], frame_marker_i};
      dra_sync <= {dra_sync[0], rx_data_port_a_i};
      drb_sync <= {drb_sync[0], rx_data_port_b_i};
    end
  end

  // 8.192 mhz is under half of mclk, so every pcm edge is seen
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pclk_prev <= 1'b0;
    end else begin
      pclk_prev <= pclk_sync[1];
    end
  end

  assign pclk_rise = pclk_sync[1] && !pclk_prev;
  assign pclk_fall = !pclk_sync[1] && pclk_prev;
  assign frame_start = pclk_fall && fs_sync[1] && !fs_prev;
  assign tx_edge = tx_edge_rising_i ? pclk_rise : pclk_fall;

  // frame marker sampled on falling edges of the pcm clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fs_prev <= 1'b0;
      frame_seen <= 1'b0;
    end else if (pclk_fall) begin
      fs_prev <= fs_sync[1];
      if (frame_start) begin
        frame_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    if (frame_start) begin
      next_cnt = CNT_RST;
    end else if (bit_cnt == CNT_MAX) begin
      next_cnt = bit_cnt;
    end else begin
      next_cnt = bit_cnt + 11'h001;
    end
  end

  // saturating bit counter; a missing marker cannot wrap onto slot 0
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bit_cnt <= CNT_MAX;
    end else if (pclk_fall) begin
      bit_cnt <= next_cnt;
    end
  end

  assign linear = (code_sel_i == CODE_LINEAR);
  assign sig_en = pcm_signalling_select_i && !linear;
  assign tx_len = (linear || sig_en) ? LEN_WORD : LEN_BYTE;
  assign rx_len = linear ? LEN_WORD : LEN_BYTE;
  assign tx_start = slot_start(tx_slot_select_i, tx_bit_offset_i);
  assign rx_start = slot_start(rx_slot_select_i, rx_bit_offset_i);

  always_comb begin
    sig_byte = 8'h00;
    sig_byte[SIG_DET1_BIT] = line_detect_one_i;
    sig_byte[SIG_DET2_BIT] = line_alt_sel_i ? line_detect_alt_i :
      line_detect_two_i;
    sig_byte[SIG_CLOCK_FAIL_FLAG_BIT] = clock_fail_flag_i;
  end

  // sample captured at the marker so a word never tears mid-slot
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_hold <= WORD_RST;
    end else if (frame_start) begin
      tx_hold <= tx_sample_i;
    end
  end

  // with falling-edge transmit, slot 0 loads in the marker cycle, before tx_hold has the new sample
  assign tx_src = frame_start ? tx_sample_i : tx_hold;

  always_comb begin
    if (linear) begin
      tx_word = tx_src;
    end else if (sig_en) begin
      tx_word = {tx_src[7:0], sig_byte};
    end else begin
      tx_word = {tx_src[7:0], 8'h00};
    end
  end

  // rising edges use the count already advanced at the last falling edge
  assign tx_pos = tx_edge_rising_i ? bit_cnt : next_cnt;
  assign tx_load = tx_edge && frame_seen && (tx_pos == tx_start);

  // the marker ends a slot cut short by a fractional frame tail
  pcmts_tx_shift u_tx (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(tx_load),
    .shift_i(tx_edge),
    .abort_i(frame_start),
    .len_i(tx_len),
    .word_i(tx_word),
    .bit_o(tx_bit),
    .busy_o(tx_busy)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_data_port_a_o <= 1'b0;
      tx_data_port_b_o <= 1'b0;
      tx_slot_active_a_n_o <= 1'b1;
      tx_slot_active_b_n_o <= 1'b1;
    end else begin
      tx_data_port_a_o <= tx_busy && tx_port_sel_i[0] && tx_bit;
      tx_data_port_b_o <= tx_busy && tx_port_sel_i[1] && tx_bit;
      tx_slot_active_a_n_o <= !(tx_busy && tx_port_sel_i[0]);
      tx_slot_active_b_n_o <= !(tx_busy && tx_port_sel_i[1]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_readback_o <= WORD_RST;
    end else if (tx_load) begin
      tx_readback_o <= tx_word;
    end
  end

  // a receive slot cut by the next marker never raises valid
  assign rx_end = rx_start + {6'h00, rx_len} - 11'h001;
  assign rx_sample = pclk_fall && frame_seen && (next_cnt >= rx_start) &&
    (next_cnt <= rx_end);
  assign rx_last = (next_cnt == rx_end);
  assign rx_bit = rx_port_b_sel_i ? drb_sync[1] : dra_sync[1];

  pcmts_rx_shift u_rx (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sample_i(rx_sample),
    .last_i(rx_last),
    .bit_i(rx_bit),
    .code_i(code_sel_i),
    .word_o(rx_word_o),
    .valid_o(rx_valid_o)
  );

  // helper: bits shifted out during the current transmission
  logic [4:0] tx_sent;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_sent <= 5'h00;
    end else if (tx_load) begin
      tx_sent <= 5'h01;
    end else if (tx_edge && tx_busy) begin
      tx_sent <= tx_sent + 5'h01;
    end
  end

  sequence s_load_seen;
    tx_load ##1 tx_busy;
  endsequence

  sequence s_strobe_a_on;
    tx_busy && tx_port_sel_i[0];
  endsequence

  a_frame_count_zero: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    frame_start |=> bit_cnt == CNT_RST)
    else $error("bit count not zero after frame marker");

  a_tx_start_pos: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $rose(tx_busy) |-> $past(tx_pos) == $past(tx_start))
    else $error("transmit began away from programmed bit");

  a_msb_first_out: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_load_seen |-> tx_bit == $past(tx_word[WORD_W-1], 1))
    else $error("first transmitted bit is not the msb");

  a_tx_length_bits: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $fell(tx_busy) && !$past(frame_start) && !$past(tx_load) |->
      $past(tx_sent) == $past(tx_len))
    else $error("transmit length wrong for coding");

  a_strobe_port_a: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_strobe_a_on |=> tx_slot_active_a_n_o == 1'b0)
    else $error("port a strobe not asserted");

  a_strobe_port_b: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !tx_slot_active_b_n_o |-> $past(tx_port_sel_i[1]) && $past(tx_busy))
    else $error("port b strobe without selection");

  a_edge_timing: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    $changed(tx_slot_active_a_n_o) |->
      $past(tx_edge, 2) || $past(frame_start, 2))
    else $error("strobe moved away from the selected edge");

  a_signal_byte: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    tx_load && sig_en |=>
      tx_readback_o[SIG_DET1_BIT] == $past(line_detect_one_i) &&
      tx_readback_o[SIG_CLOCK_FAIL_FLAG_BIT] == $past(clock_fail_flag_i))
    else $error("signalling byte content wrong");

  a_readback_word: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    s_load_seen |-> tx_readback_o == $past(tx_word))
    else $error("readback does not match sent word");

  a_rx_valid_pulse: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    rx_valid_o |-> $past(rx_sample) && $past(rx_last) ##1 !rx_valid_o)
    else $error("receive valid not a single end-of-slot pulse");

  // the word must stand until the next valid pulse
  a_rx_word_stable: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !rx_valid_o |-> $stable(rx_word_o))
    else $error("receive word moved without valid");

  a_no_tx_unsynced: assert property (
    @(posedge mclk_i) disable iff (sys_rst_i)
    !frame_seen |-> tx_slot_active_a_n_o && tx_slot_active_b_n_o &&
      !rx_valid_o)
    else $error("slot activity before first frame marker");
endmodule // pcmts_assigner

// ### tb/pcmts_hwy.sv
/*
  highway model: bit clock, frame marker, receive data, transmit capture.
  assumes the assigner counts bits from the falling edge that sees the
  marker high.
*/
`timescale 1ns/1ns
module pcmts_hwy #(
  parameter int HALF_NS = 240,
  // whole slots only, so the last full slot stays usable
  parameter int FRAME_BITS = 64
) (
  // transmit side seen
  input wire logic edge_rise_i,
  input wire logic [1:0] dx_i,
  input wire logic [1:0] strb_n_i,
  // receive word to send
  input wire logic [15:0] rx_word_i,
  input wire logic [10:0] rx_first_i,
  input wire logic [4:0] rx_len_i,
  input wire logic rx_b_i,
  // pins and results of last frame
  output logic pcm_clk_o,
  output logic fs_o,
  output logic [1:0] dr_o,
  output logic [1:0][15:0] cap_w_o,
  output logic [1:0][7:0] cap_n_o,
  output logic [1:0][10:0] cap_f_o
);
  int cnt = FRAME_BITS - 3;
  int nxt;
  int k;
  logic [1:0][15:0] w = '0;
  logic [1:0][7:0] n = '0;
  logic [1:0][10:0] f = '0;
  initial begin
    pcm_clk_o = 1'b1;
    fs_o = 1'b0;
    dr_o = 2'h0;
    cap_w_o = '0;
    cap_n_o = '0;
    cap_f_o = '0;
  end
  // a backplane bit clock runs free, frames or not
  always #(HALF_NS) pcm_clk_o = ~pcm_clk_o;
  // sample transmit half a period after it moved
  task automatic grab(input int idx);
    for (int p = 0; p < 2; p++) begin
      if (strb_n_i[p] === 1'b0) begin
        if (n[p] == 8'h00) f[p] = idx[10:0];
        w[p] = {w[p][14:0], dx_i[p]};
        n[p] = n[p] + 8'h01;
      end
    end
  endtask
  always @(negedge pcm_clk_o) begin
    if (edge_rise_i) grab(cnt);
    cnt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      cap_w_o = w;
      cap_n_o = n;
      cap_f_o = f;
      w = '0;
      n = '0;
      f = '0;
    end
  end
  always @(posedge pcm_clk_o) begin
    if (!edge_rise_i) grab(cnt);
    nxt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    fs_o = (nxt == 0);
    k = nxt - int'(rx_first_i);
    if (k >= 0 && k < int'(rx_len_i)) begin
      // msb first on the selected port, inverse on the other
      dr_o[rx_b_i] = rx_word_i[int'(rx_len_i) - 1 - k];
      dr_o[!rx_b_i] = ~rx_word_i[int'(rx_len_i) - 1 - k];
    end else begin
      // nothing driven: a toggling level, not a held one
      dr_o = {nxt[0], ~nxt[0]};
    end
  end
endmodule // pcmts_hwy

// ### tb/tb_pcm_highway_slot_assigner.sv
/*
  testbench for the slot assigner: three scenarios against the highway
  model. assumes mclk at 25 mhz and a bit clock near 2 mhz.
*/
`timescale 1ns/1ns
module tb_pcm_highway_slot_assigner;
  import pcmts_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pclk, fs, rx_b, edge_r, sig_sel, rx_valid;
  logic [1:0] dr, dx, strb_n, port_sel;
  logic [6:0] tx_slot, rx_slot;
  logic [2:0] tx_ofs, rx_ofs;
  pcmts_code_e code;
  logic [15:0] sample, rx_word, readback, rx_send, rx_got;
  logic [1:0][15:0] cap_w;
  logic [1:0][7:0] cap_n;
  logic [1:0][10:0] cap_f;
  logic [10:0] rx_first;
  logic [4:0] rx_len;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  assign rx_first = {1'b0, rx_slot, 3'h0} + {8'h00, rx_ofs};
  assign rx_len = (code == CODE_LINEAR) ? LEN_WORD : LEN_BYTE;
  pcmts_assigner dut_u (
    .mclk_i(mclk), .sys_rst_i(rst), .pcm_clk_i(pclk),
    .frame_marker_i(fs), .rx_data_port_a_i(dr[0]),
    .rx_data_port_b_i(dr[1]), .tx_data_port_a_o(dx[0]),
    .tx_data_port_b_o(dx[1]), .tx_slot_active_a_n_o(strb_n[0]),
    .tx_slot_active_b_n_o(strb_n[1]), .tx_slot_select_i(tx_slot),
    .tx_bit_offset_i(tx_ofs), .rx_slot_select_i(rx_slot),
    .rx_bit_offset_i(rx_ofs), .code_sel_i(code),
    .pcm_signalling_select_i(sig_sel), .tx_port_sel_i(port_sel),
    .rx_port_b_sel_i(rx_b), .tx_edge_rising_i(edge_r),
    .line_detect_one_i(1'b1), .line_detect_two_i(1'b0),
    .line_detect_alt_i(1'b1), .line_alt_sel_i(1'b1),
    .clock_fail_flag_i(1'b1), .tx_sample_i(sample),
    .rx_word_o(rx_word), .rx_valid_o(rx_valid), .tx_readback_o(readback)
  );
  pcmts_hwy hwy_u (
    .edge_rise_i(edge_r), .dx_i(dx), .strb_n_i(strb_n),
    .rx_word_i(rx_send), .rx_first_i(rx_first), .rx_len_i(rx_len),
    .rx_b_i(rx_b), .pcm_clk_o(pclk), .fs_o(fs), .dr_o(dr),
    .cap_w_o(cap_w), .cap_n_o(cap_n), .cap_f_o(cap_f)
  );
  initial begin
    {sig_sel, rx_b, edge_r, port_sel} = 5'h01;
    {tx_slot, tx_ofs, rx_slot, rx_ofs} = 20'h00000;
    code = CODE_ALAW;
    sample = 16'h0000;
    rx_send = 16'h0000;
  end
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) rx_got <= rx_word;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // two frames cover a mid-frame change plus one clean frame
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [15:0] got,
                     input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apply(input pcmts_code_e c, input logic [4:0] flags,
                       input logic [19:0] slots, input logic [15:0] smp,
                       input logic [15:0] rw);
    @(posedge mclk);
    #5;
    code = c;
    {sig_sel, rx_b, edge_r, port_sel} = flags;
    {tx_slot, tx_ofs, rx_slot, rx_ofs} = slots;
    sample = smp;
    rx_send = rw;
    repeat (2) @(posedge fs);
    repeat (20) @(posedge mclk);
  endtask
  task automatic sc_linear();
    apply(CODE_LINEAR, 5'h11, {7'h02, 3'h5, 7'h04, 3'h3}, 16'hA5C3,
          16'h9E61);
    chk("first_a", {5'h00, cap_f[0]}, 16'h0015);
    chk("len_a", {8'h00, cap_n[0]}, 16'h0010);
    chk("word_a", cap_w[0], 16'hA5C3);
    chk("len_b", {8'h00, cap_n[1]}, 16'h0000);
    chk("readback", readback, 16'hA5C3);
    chk("rx_lin", rx_got, 16'h9E61);
  endtask
  task automatic sc_signalling();
    apply(CODE_MULAW, 5'h1E, {7'h05, 3'h7, 7'h01, 3'h0}, 16'h0037,
          16'h0080);
    chk("first_b", {5'h00, cap_f[1]}, 16'h002F);
    chk("len_b", {8'h00, cap_n[1]}, 16'h0010);
    chk("word_b", cap_w[1], 16'h37C4);
    chk("len_a", {8'h00, cap_n[0]}, 16'h0000);
    chk("readback", readback, 16'h37C4);
    chk("rx_mu", rx_got, 16'h7D7C);
  endtask
  task automatic sc_both_ports();
    apply(CODE_ALAW, 5'h03, {7'h00, 3'h0, 7'h07, 3'h0}, 16'hFF5A,
          16'h00AA);
    chk("first_a", {5'h00, cap_f[0]}, 16'h0000);
    chk("len_a", {8'h00, cap_n[0]}, 16'h0008);
    chk("word_a", cap_w[0], 16'h005A);
    chk("word_b", cap_w[1], 16'h005A);
    chk("rx_a", rx_got, 16'h7E00);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    chk("strobe_rst", {14'h0000, strb_n}, 16'h0003);
    #5;
    rst = 1'b0;
    sc_linear();
    sc_signalling();
    sc_both_ports();
    close_out();
  end
endmodule // tb_pcm_highway_slot_assigner
